// ==== hw/dgp_top.sv ====
// Dual eight-bit GPIO ports C and D behind an AXI4-Lite slave
//
// How it works
// - Port C has eight pins, each direction set by its own bit.
// - Port C direction bit 1 tristates the pin, making it an input.
// - Port C direction bit 0 drives the pin from the output latch.
// - Port C latch is addressable; reads return latched value, not pins.
// - An enabled peripheral may force a port C pin to output or input.
// - Peripheral forcing never alters the stored direction register.
// - Every reset sets all port C and D direction bits to one.
// - Latch contents survive non power-on resets, pin outputs clear on every reset; latches cleared to zero after power-on.
// - Capture/compare two sits on port C pin one when select bit is one.
// - Pins 0..2 share timer-one oscillator/clock and capture/compare one.
// - Pins 3..5 share serial clock, serial data in, serial data out.
// - Pins 6 and 7 share USART transmit/clock and receive/data.
// - Port D direction 1 gives input, 0 drives matching latch bit.
// - Port D latch is addressable; reads return latched value.
// - Port D has eight independently configurable pins.
// - Slave-port select hands port D over to the parallel slave port.
// - Slave-port select: 1 slave port, 0 GPIO, resets to 0.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "dgp_defs.svh"

module dgp_top
    import dgp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Power-on/brown-out flag: latches are cleared only when it is set
    input wire logic POR_FLAG,
    input wire logic CAPTURE_TWO_PIN_SELECT,
    // Peripheral overrides, three bits (enable, drive, value) per port C pin
    input wire dgp_override_type PERIPH_OVR,
    input wire logic [WIDTH-1:0] PORT_C_IN,
    output logic [WIDTH-1:0] PORT_C_OUT,
    output logic [WIDTH-1:0] PORT_C_OE,
    input wire logic [WIDTH-1:0] PORT_D_IN,
    output logic [WIDTH-1:0] PORT_D_OUT,
    output logic [WIDTH-1:0] PORT_D_OE,
    output logic SLAVE_PORT_SELECT,
    output logic CAPTURE_TWO_ON_PORT_C,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);

    // ********************************************************
    // Register state
    // ********************************************************
    logic [WIDTH-1:0] port_c_output_latch, next_port_c_output_latch;
    logic [WIDTH-1:0] port_c_direction, next_port_c_direction;
    logic [WIDTH-1:0] port_d_output_latch, next_port_d_output_latch;
    logic [WIDTH-1:0] port_d_direction, next_port_d_direction;
    logic slave_port_select, next_slave_port_select;

    // ********************************************************
    // Bus state
    // ********************************************************
    logic [7:0] aw_addr, next_aw_addr;
    logic aw_have, next_aw_have;
    logic [31:0] w_data, next_w_data;
    logic w_have, next_w_have;
    logic w_strb0, next_w_strb0;
    dgp_wr_state_type wr_state, next_wr_state;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;
    // Handshake outputs kept as their own flops, not decoded from state
    logic aw_ready, next_aw_ready, w_ready, next_w_ready;
    logic ar_ready, next_ar_ready, bvalid, next_bvalid;
    logic [WIDTH-1:0] c_out, next_c_out, c_oe, next_c_oe;
    logic [WIDTH-1:0] d_out, next_d_out, d_oe, next_d_oe;

    logic do_write;
    logic [WIDTH-1:0] wbyte;
    logic [WIDTH-1:0] c_eff_out;

    assign do_write = aw_have && w_have && (wr_state == DGP_WR_IDLE);
    assign wbyte = w_data[WIDTH-1:0];

    // ********************************************************
    // Register writes
    // ********************************************************
    always_comb begin
        next_port_c_output_latch = port_c_output_latch;
        next_port_c_direction = port_c_direction;
        next_port_d_output_latch = port_d_output_latch;
        next_port_d_direction = port_d_direction;
        next_slave_port_select = slave_port_select;
        next_bresp = bresp;
        next_wr_state = wr_state;
        if (do_write) begin
            next_wr_state = DGP_WR_RESP;
            next_bresp = `DGP_RESP_OKAY;
            if (!w_strb0) begin
                // Lane 0 not enabled: nothing to store
            end else if (aw_addr == `DGP_OFS_PC_PIN
                    || aw_addr == `DGP_OFS_PC_LAT) begin
                next_port_c_output_latch = wbyte;
            end else if (aw_addr == `DGP_OFS_PC_DIR) begin
                next_port_c_direction = wbyte;
            end else if (aw_addr == `DGP_OFS_PD_PIN
                    || aw_addr == `DGP_OFS_PD_LAT) begin
                next_port_d_output_latch = wbyte;
            end else if (aw_addr == `DGP_OFS_PD_DIR) begin
                next_port_d_direction = wbyte;
            end else if (aw_addr == `DGP_OFS_SP_CTL) begin
                next_slave_port_select = wbyte[`DGP_SP_SEL_BIT];
            end else if (aw_addr == `DGP_OFS_PC_OVR) begin
                // Read-only view, write ignored
            end else begin
                next_bresp = `DGP_RESP_SLVERR;
            end
            if (w_strb0 && aw_addr[1:0] != 2'h0) begin
                next_bresp = `DGP_RESP_SLVERR;
            end
        end else if (wr_state == DGP_WR_RESP && S_AXI_BREADY) begin
            next_wr_state = DGP_WR_IDLE;
        end
        next_bvalid = (next_wr_state == DGP_WR_RESP);
    end

    // Latches get no reset unless power-on: they keep value otherwise
    always_ff @(posedge CLK_SYS) begin
        if (!NRST && POR_FLAG) begin
            port_c_output_latch <= 8'h00;
            port_d_output_latch <= 8'h00;
        end else if (NRST) begin
            port_c_output_latch <= next_port_c_output_latch;
            port_d_output_latch <= next_port_d_output_latch;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            port_c_direction <= `DGP_DIR_RESET;
            port_d_direction <= `DGP_DIR_RESET;
            slave_port_select <= 1'b0;
            wr_state <= DGP_WR_IDLE;
            bresp <= `DGP_RESP_OKAY;
            bvalid <= 1'b0;
        end else begin
            port_c_direction <= next_port_c_direction;
            port_d_direction <= next_port_d_direction;
            slave_port_select <= next_slave_port_select;
            wr_state <= next_wr_state;
            bresp <= next_bresp;
            bvalid <= next_bvalid;
        end
    end

    // ********************************************************
    // Write channel capture
    // ********************************************************
    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_have = aw_have;
        next_w_data = w_data;
        next_w_have = w_have;
        next_w_strb0 = w_strb0;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_addr = S_AXI_AWADDR;
            next_aw_have = 1'b1;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_data = S_AXI_WDATA;
            next_w_strb0 = S_AXI_WSTRB[0];
            next_w_have = 1'b1;
        end
        if (do_write) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
        end
        next_aw_ready = ~next_aw_have;
        next_w_ready = ~next_w_have;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            aw_addr <= 8'h00;
            aw_have <= 1'b0;
            w_data <= 32'h0000_0000;
            w_have <= 1'b0;
            w_strb0 <= 1'b0;
            aw_ready <= 1'b1;
            w_ready <= 1'b1;
        end else begin
            aw_addr <= next_aw_addr;
            aw_have <= next_aw_have;
            w_data <= next_w_data;
            w_have <= next_w_have;
            w_strb0 <= next_w_strb0;
            aw_ready <= next_aw_ready;
            w_ready <= next_w_ready;
        end
    end

    // ********************************************************
    // Read channel
    // ********************************************************
    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (S_AXI_ARVALID && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = `DGP_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (S_AXI_ARADDR == `DGP_OFS_PC_PIN) begin
                next_rdata[WIDTH-1:0] = PORT_C_IN;
            end else if (S_AXI_ARADDR == `DGP_OFS_PC_LAT) begin
                next_rdata[WIDTH-1:0] = port_c_output_latch;
            end else if (S_AXI_ARADDR == `DGP_OFS_PC_DIR) begin
                // Stored value only; overrides never show here
                next_rdata[WIDTH-1:0] = port_c_direction;
            end else if (S_AXI_ARADDR == `DGP_OFS_PD_PIN) begin
                next_rdata[WIDTH-1:0] = PORT_D_IN;
            end else if (S_AXI_ARADDR == `DGP_OFS_PD_LAT) begin
                next_rdata[WIDTH-1:0] = port_d_output_latch;
            end else if (S_AXI_ARADDR == `DGP_OFS_PD_DIR) begin
                next_rdata[WIDTH-1:0] = port_d_direction;
            end else if (S_AXI_ARADDR == `DGP_OFS_SP_CTL) begin
                next_rdata[`DGP_SP_SEL_BIT] = slave_port_select;
            end else if (S_AXI_ARADDR == `DGP_OFS_PC_OVR) begin
                next_rdata[WIDTH-1:0] = PERIPH_OVR.force_en;
            end else begin
                next_rresp = `DGP_RESP_SLVERR;
            end
        end else if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
        next_ar_ready = ~next_rvalid;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `DGP_RESP_OKAY;
            ar_ready <= 1'b1;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            ar_ready <= next_ar_ready;
        end
    end

    // ********************************************************
    // Pin drivers
    // ********************************************************
    // Peripheral functions on C pins 0..7 (timer osc, capture/compare,
    // serial port, USART) arrive only as override vectors.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pc
            always_comb begin
                if (PERIPH_OVR.force_en[i]) begin
                    next_c_oe[i] = PERIPH_OVR.force_out[i];
                    c_eff_out[i] = PERIPH_OVR.force_val[i];
                end else begin
                    next_c_oe[i] = ~port_c_direction[i];
                    c_eff_out[i] = port_c_output_latch[i];
                end
                next_c_out[i] = c_eff_out[i];
                // Slave port owns D pins; its drive is outside this block
                next_d_oe[i] = ~slave_port_select
                    & ~port_d_direction[i];
                next_d_out[i] = port_d_output_latch[i];
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            c_out <= 8'h00;
            c_oe <= 8'h00;
            d_out <= 8'h00;
            d_oe <= 8'h00;
        end else begin
            c_out <= next_c_out;
            c_oe <= next_c_oe;
            d_out <= next_d_out;
            d_oe <= next_d_oe;
        end
    end

    assign PORT_C_OUT = c_out;
    assign PORT_C_OE = c_oe;
    assign PORT_D_OUT = d_out;
    assign PORT_D_OE = d_oe;
    assign SLAVE_PORT_SELECT = slave_port_select;
    assign S_AXI_AWREADY = aw_ready;
    assign S_AXI_WREADY = w_ready;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_ARREADY = ar_ready;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = rresp;

    // Strap sampled by a clocked process, never under reset
    always_ff @(posedge CLK_SYS) begin
        CAPTURE_TWO_ON_PORT_C <= CAPTURE_TWO_PIN_SELECT;
    end

endmodule : dgp_top
`default_nettype wire

// ==== include/dgp_defs.svh ====
// Register offsets, field positions and reset values for the dual GPIO port
`ifndef DGP_DEFS_SVH
`define DGP_DEFS_SVH

`define DGP_OFS_PC_PIN 8'h00
`define DGP_OFS_PC_LAT 8'h04
`define DGP_OFS_PC_DIR 8'h08
`define DGP_OFS_PD_PIN 8'h0C
`define DGP_OFS_PD_LAT 8'h10
`define DGP_OFS_PD_DIR 8'h14
`define DGP_OFS_SP_CTL 8'h18
`define DGP_OFS_PC_OVR 8'h1C

`define DGP_DIR_RESET 8'hFF
`define DGP_SP_SEL_BIT 4
`define DGP_RESP_OKAY 2'h0
`define DGP_RESP_SLVERR 2'h2

`endif

// ==== include/dgp_pkg.sv ====
// Types shared by the dual GPIO port
`default_nettype none
package dgp_pkg;

    typedef struct packed {
        logic [7:0] val;
        logic [7:0] oe;
    } dgp_drive_type;

    typedef struct packed {
        logic [7:0] force_en;
        logic [7:0] force_out;
        logic [7:0] force_val;
    } dgp_override_type;

    typedef enum logic [0:0] {
        DGP_WR_IDLE,
        DGP_WR_RESP
    } dgp_wr_state_type;

endpackage : dgp_pkg
`default_nettype wire

// ==== dv/dgp_top_asserts.sv ====
// Concurrent checks on the dual GPIO port top-level pins
`timescale 1ns/10ps
`default_nettype none
module dgp_top_asserts
    import dgp_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic CAPTURE_TWO_PIN_SELECT,
    input wire dgp_override_type PERIPH_OVR,
    input wire logic [WIDTH-1:0] PORT_C_OUT,
    input wire logic [WIDTH-1:0] PORT_C_OE,
    input wire logic [WIDTH-1:0] PORT_D_OE,
    input wire logic SLAVE_PORT_SELECT,
    input wire logic CAPTURE_TWO_ON_PORT_C,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);
    // Reset itself is the cause here, so this one is never disabled
    property p_rst;
        disable iff (1'b0)
        !NRST |=> PORT_C_OE == 8'h00 && PORT_D_OE == 8'h00
            && !SLAVE_PORT_SELECT;
    endproperty
    a_rst: assert property (p_rst) else $error("pins not idle after reset");
    property p_ovr;
        1'b1 |=> (((PORT_C_OE ^ $past(PERIPH_OVR.force_out))
            | (PORT_C_OUT ^ $past(PERIPH_OVR.force_val)))
            & $past(PERIPH_OVR.force_en)) == 8'h00;
    endproperty
    a_ovr: assert property (p_ovr) else $error("override not on pin");
    property p_sps;
        SLAVE_PORT_SELECT |=> PORT_D_OE == 8'h00;
    endproperty
    a_sps: assert property (p_sps) else $error("port D driven in PSP");
    property p_cap_two;
        1'b1 |=> CAPTURE_TWO_ON_PORT_C == $past(CAPTURE_TWO_PIN_SELECT);
    endproperty
    a_cap_two: assert property (p_cap_two) else $error("strap not followed");
    property p_rd_lat;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("late read data");
    property p_wr_lat;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
            |-> ##2 S_AXI_BVALID;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("late write reply");
    property p_rd_hi;
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000;
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper bits set");
    property p_rd_err;
        S_AXI_RVALID && S_AXI_RRESP != 2'h0 |-> S_AXI_RDATA == 32'h0;
    endproperty
    a_rd_err: assert property (p_rd_err) else $error("error data not 0");
    c_sps: cover property ($rose(SLAVE_PORT_SELECT));
    c_ovr: cover property (PERIPH_OVR.force_en != 8'h00);
    c_err: cover property (S_AXI_RVALID && S_AXI_RRESP != 2'h0);
endmodule : dgp_top_asserts
bind dgp_top dgp_top_asserts #(.WIDTH(WIDTH)) u_chk (.*);
`default_nettype wire

// ==== dv/dgp_pins.sv ====
// Board model for one 8-bit port: driver wins, else board, else float
`timescale 1ns/10ps
`default_nettype none
module dgp_pins (
    input wire logic clk,
    input wire logic [7:0] out,
    input wire logic [7:0] oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin
);
    logic [7:0] held = 8'h00;
    always_ff @(posedge clk) begin
        held <= pin;
    end
    // Floating pins toggle so a stale value is never read as good
    always_comb begin
        pin = (out & oe) | (ext_val & ext_en & ~oe)
            | (~held & ~ext_en & ~oe);
    end
endmodule : dgp_pins
`default_nettype wire

// ==== dv/dgp_top_test.sv ====
// Self-checking bench for the dual GPIO port
`timescale 1ns/10ps
`default_nettype none
`include "dgp_defs.svh"
module dgp_top_test
    import dgp_pkg::*;
    ;
    localparam int LIMIT = 5000;
    logic CLK_SYS, NRST, POR_FLAG, CAPTURE_TWO_PIN_SELECT;
    dgp_override_type PERIPH_OVR;
    logic [7:0] PORT_C_IN, PORT_C_OUT, PORT_C_OE, PORT_D_IN, PORT_D_OUT;
    logic [7:0] PORT_D_OE, S_AXI_AWADDR, S_AXI_ARADDR, ce, cv, de, dv;
    logic SLAVE_PORT_SELECT, CAPTURE_TWO_ON_PORT_C;
    logic S_AXI_AWVALID, S_AXI_AWREADY;
    logic S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
    logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    dgp_top dut (.*);
    dgp_pins u_pc (.clk(CLK_SYS), .out(PORT_C_OUT), .oe(PORT_C_OE),
        .ext_en(ce), .ext_val(cv), .pin(PORT_C_IN));
    dgp_pins u_pd (.clk(CLK_SYS), .out(PORT_D_OUT), .oe(PORT_D_OE),
        .ext_en(de), .ext_val(dv), .pin(PORT_D_IN));
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    task automatic print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            print_verdict;
        end
    end
    task automatic chk(input string nm, input logic [33:0] e, g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
        @(posedge CLK_SYS);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h000000, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
        end while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
        chk("bresp", 34'(er), 34'(S_AXI_BRESP));
    endtask : wr
    task automatic rd(input logic [7:0] a, d, input logic [1:0] er);
        @(posedge CLK_SYS);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CLK_SYS);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
        end while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
        chk("rdata", {er, 24'h000000, d}, {S_AXI_RRESP, S_AXI_RDATA});
    endtask : rd
    task automatic do_reset(input logic por);
        NRST <= 1'b0;
        POR_FLAG <= por;
        repeat (5) @(posedge CLK_SYS);
        NRST <= 1'b1;
        POR_FLAG <= 1'b0;
    endtask : do_reset
    task automatic t_reset;
        rd(`DGP_OFS_PC_DIR, `DGP_DIR_RESET, `DGP_RESP_OKAY);
        rd(`DGP_OFS_PD_DIR, `DGP_DIR_RESET, `DGP_RESP_OKAY);
        rd(`DGP_OFS_SP_CTL, 8'h00, `DGP_RESP_OKAY);
        chk("c_oe", 34'h0, 34'(PORT_C_OE));
        chk("d_oe", 34'h0, 34'(PORT_D_OE));
        chk("cap_two", 34'h1, 34'(CAPTURE_TWO_ON_PORT_C));
        CAPTURE_TWO_PIN_SELECT <= 1'b0;
        repeat (2) @(posedge CLK_SYS);
        chk("cap_two", 34'h0, 34'(CAPTURE_TWO_ON_PORT_C));
    endtask : t_reset
    task automatic t_port_c;
        wr(`DGP_OFS_PC_LAT, 8'h5A, `DGP_RESP_OKAY);
        wr(`DGP_OFS_PC_DIR, 8'hCF, `DGP_RESP_OKAY);
        repeat (2) @(posedge CLK_SYS);
        chk("c_oe", 34'h30, 34'(PORT_C_OE));
        chk("c_out", 34'h10, 34'(PORT_C_OUT & 8'h30));
        rd(`DGP_OFS_PC_PIN, (cv & 8'hCF) | 8'h10, `DGP_RESP_OKAY);
        rd(`DGP_OFS_PC_LAT, 8'h5A, `DGP_RESP_OKAY);
        // Drive and value differ so a swap of the two fields shows
        PERIPH_OVR <= {8'hC3, 8'h41, 8'h82};
        repeat (2) @(posedge CLK_SYS);
        chk("ovr_oe", 34'h71, 34'(PORT_C_OE));
        chk("ovr_out", 34'h82, 34'(PORT_C_OUT & 8'hC3));
        rd(`DGP_OFS_PC_OVR, 8'hC3, `DGP_RESP_OKAY);
        rd(`DGP_OFS_PC_DIR, 8'hCF, `DGP_RESP_OKAY);
        PERIPH_OVR <= 24'h000000;
        wr(`DGP_OFS_PC_PIN, 8'h3C, `DGP_RESP_OKAY);
        rd(`DGP_OFS_PC_LAT, 8'h3C, `DGP_RESP_OKAY);
        S_AXI_WSTRB <= 4'hE;
        wr(`DGP_OFS_PC_LAT, 8'hFF, `DGP_RESP_OKAY);
        S_AXI_WSTRB <= 4'hF;
        rd(`DGP_OFS_PC_LAT, 8'h3C, `DGP_RESP_OKAY);
    endtask : t_port_c
    task automatic t_port_d;
        wr(`DGP_OFS_PD_LAT, 8'hA5, `DGP_RESP_OKAY);
        wr(`DGP_OFS_PD_DIR, 8'h0F, `DGP_RESP_OKAY);
        repeat (2) @(posedge CLK_SYS);
        chk("d_oe", 34'hF0, 34'(PORT_D_OE));
        chk("d_out", 34'hA0, 34'(PORT_D_OUT & 8'hF0));
        rd(`DGP_OFS_PD_PIN, (dv & 8'h0F) | 8'hA0, `DGP_RESP_OKAY);
        rd(`DGP_OFS_PD_LAT, 8'hA5, `DGP_RESP_OKAY);
        wr(`DGP_OFS_SP_CTL, 8'hFF, `DGP_RESP_OKAY);
        rd(`DGP_OFS_SP_CTL, 8'h10, `DGP_RESP_OKAY);
        repeat (2) @(posedge CLK_SYS);
        chk("sps", 34'h1, 34'(SLAVE_PORT_SELECT));
        chk("psp_oe", 34'h0, 34'(PORT_D_OE));
        wr(`DGP_OFS_SP_CTL, 8'h00, `DGP_RESP_OKAY);
        repeat (2) @(posedge CLK_SYS);
        chk("gpio_oe", 34'hF0, 34'(PORT_D_OE));
    endtask : t_port_d
    task automatic t_bus_err;
        rd(8'h20, 8'h00, `DGP_RESP_SLVERR);
        wr(8'h20, 8'h00, `DGP_RESP_SLVERR);
        wr(8'h06, 8'h00, `DGP_RESP_SLVERR);
        wr(`DGP_OFS_PC_OVR, 8'h00, `DGP_RESP_OKAY);
    endtask : t_bus_err
    task automatic t_warm;
        do_reset(1'b0);
        rd(`DGP_OFS_PC_LAT, 8'h3C, `DGP_RESP_OKAY);
        rd(`DGP_OFS_PD_LAT, 8'hA5, `DGP_RESP_OKAY);
        rd(`DGP_OFS_PC_DIR, `DGP_DIR_RESET, `DGP_RESP_OKAY);
        do_reset(1'b1);
        rd(`DGP_OFS_PC_LAT, 8'h00, `DGP_RESP_OKAY);
    endtask : t_warm
    initial begin
        CAPTURE_TWO_PIN_SELECT <= 1'b1;
        PERIPH_OVR <= 24'h000000;
        {ce, cv, de, dv} <= {8'hFF, 8'h69, 8'hFF, 8'h3C};
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} <= 48'h0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h0;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h0;
        S_AXI_WSTRB <= 4'hF;
        do_reset(1'b1);
        t_reset;
        t_port_c;
        t_port_d;
        t_bus_err;
        t_warm;
        print_verdict;
    end
endmodule : dgp_top_test
`default_nettype wire
